// [hw/ufc_params.svh]
// offsets, field positions and reset values of the fifo mapping block
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
`define UFC_ADDR_W 9
`define UFC_OFS_EPMAP0 9'h1A0
`define UFC_OFS_EPMAP1 9'h1A4
`define UFC_OFS_FMAP 9'h1A8
`define UFC_OFS_FCFG 9'h1AC
`define UFC_OFS_STATUS 9'h1C0
`define UFC_FIFO_STEP 8
`define UFC_EPNO_LSB 0
`define UFC_DIR_LSB 4
`define UFC_KIND_LSB 0
`define UFC_CNT_LSB 2
`define UFC_SIZE_BIT 4
`define UFC_EN_BIT 5
`define UFC_EPQ_IN_LSB 0
`define UFC_EPQ_OUT_LSB 4
`define UFC_FMAP_RST 32'h0F0F0F0F
`define UFC_FMAP_MASK 32'h3F3F3F3F
`define UFC_FCFG_RST 32'h00000000
`define UFC_FCFG_MASK 32'h3F3F3F3F
`define UFC_EPMAP_RST 32'h33333333
`define UFC_EPMAP_MASK 32'h33333333
`define UFC_SMALL_MAX 16'h0200
`define UFC_LARGE_MAX 16'h0400
`endif

// [hw/ufc_pkg.sv]
// types of the fifo mapping block
package ufc_pkg;
  typedef enum logic [1:0] {
    UFC_DIR_OUT = 2'h0,
    UFC_DIR_IN = 2'h1,
    UFC_DIR_BIDIR = 2'h2,
    UFC_DIR_BAD = 2'h3
  } ufc_dir_t;
  typedef enum logic [1:0] {
    UFC_KIND_RSVD = 2'h0,
    UFC_KIND_ISO = 2'h1,
    UFC_KIND_BULK = 2'h2,
    UFC_KIND_INTR = 2'h3
  } ufc_kind_t;
  typedef enum logic [1:0] {
    UFC_CNT_ONE = 2'h0,
    UFC_CNT_TWO = 2'h1,
    UFC_CNT_THREE = 2'h2,
    UFC_CNT_RSVD = 2'h3
  } ufc_cnt_t;
endpackage

// [hw/ufc_cfg_word.sv]
// one masked configuration word with reset value
`timescale 1ns/1ps
`default_nettype none
module ufc_cfg_word #(
  parameter logic [31:0] RST = 32'h00000000,
  parameter logic [31:0] MASK = 32'hFFFFFFFF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] word
);
  logic [31:0] word_reg;
  logic [31:0] word_next;
  always_comb begin
    word_next = word_reg;
    if (wr_en) begin
      word_next = wr_data & MASK;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= RST;
    end else begin
      word_reg <= word_next;
    end
  end
  assign word = word_reg;
endmodule
`default_nettype wire

// [hw/ufc_fifo_map.sv]
// fifo to endpoint mapping and per-fifo buffer configuration registers
// Overview of operation
// RULE1: each of four fifos holds a 4-bit endpoint (reset all ones) and a 2-bit direction (reset out; 00 out, 01 in, 10 both; 11 never programmed).
//        the map word stores a written direction 11 as is, and a fifo with direction 11 never matches a lookup.
// RULE2: the map word holds fifo n direction at bits 8n+5:8n+4 and endpoint at 8n+3:8n.
// RULE3: a set enable bit enables its fifo; fifo 3 enable is bit 29 and all fifos start disabled.
// RULE4: fifo 2 enable is bit 21, size flag bit 20, block count bits 19:18, all reset zero.
// RULE5: the size flag selects a maximum packet of 512 bytes when clear and 1024 bytes when set.
// RULE6: the block count selects one, two or three buffers; code 11 is reserved.
// RULE7: the transfer kind selects isochronous 01, bulk 10, interrupt 11; 00 is reserved.
// RULE8: fifo 3 uses enable 29, size 28, count 27:26 and kind 25:24.
// RULE9: fifo 1 uses bits 13, 12, 11:10, 9:8 and fifo 0 bits 5, 4, 3:2, 1:0, all reset zero.
// RULE10: a per-endpoint map holds a 2-bit fifo number for each in and out endpoint, reset 11.
// RULE11: a disabled fifo neither accepts nor supplies packet data for any endpoint.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_params.svh"
module ufc_fifo_map
  import ufc_pkg::*;
#(
  parameter int NUM_FIFOS = 4,
  parameter int NUM_EPS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // packet path request: endpoint number and direction (1 = in)
  input wire logic [3:0] pkt_ep,
  input wire logic pkt_is_in,
  input wire logic pkt_req,
  output logic pkt_hit,
  output logic [1:0] pkt_queue,
  output logic [10:0] pkt_max_size,
  output logic [1:0] pkt_buffer_count,
  output logic [1:0] pkt_transfer_kind,
  output logic [1:0] ep_route_queue,
  output logic [3:0] queue_enable
);
  // the byte-lane layout only has room for four fifos and eight endpoints
  if (NUM_FIFOS != 4 || NUM_EPS != 8) begin : g_bad_params
    $error("ufc_fifo_map serves exactly four fifos and eight endpoints");
  end

  // ===========================================================
  // register words
  logic [31:0] fmap_w, fcfg_w, epmap0_w, epmap1_w;
  logic wr_fmap, wr_fcfg, wr_ep0, wr_ep1;
  assign wr_fmap = reg_wr && reg_addr == `UFC_OFS_FMAP;
  assign wr_fcfg = reg_wr && reg_addr == `UFC_OFS_FCFG;
  assign wr_ep0 = reg_wr && reg_addr == `UFC_OFS_EPMAP0;
  assign wr_ep1 = reg_wr && reg_addr == `UFC_OFS_EPMAP1;

  // reserved bits are masked so they always read zero
  ufc_cfg_word #(.RST(`UFC_FMAP_RST), .MASK(`UFC_FMAP_MASK)) u_fmap ( // RULE1
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_fmap), .wr_data(reg_wdata),
    .word(fmap_w));
  ufc_cfg_word #(.RST(`UFC_FCFG_RST), .MASK(`UFC_FCFG_MASK)) u_fcfg ( // RULE3
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_fcfg), .wr_data(reg_wdata),
    .word(fcfg_w));
  ufc_cfg_word #(.RST(`UFC_EPMAP_RST), .MASK(`UFC_EPMAP_MASK)) u_ep0 ( // RULE10
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_ep0), .wr_data(reg_wdata),
    .word(epmap0_w));
  ufc_cfg_word #(.RST(`UFC_EPMAP_RST), .MASK(`UFC_EPMAP_MASK)) u_ep1 (
    .clk(clk), .sys_rst(sys_rst), .wr_en(wr_ep1), .wr_data(reg_wdata),
    .word(epmap1_w));

  // ===========================================================
  // field access
  function automatic logic [7:0] fbyte(input logic [31:0] w,
                                       input logic [1:0] q);
    fbyte = w[{q, 3'h0} +: 8]; // RULE2
  endfunction

  function automatic logic [3:0] q_ep(input logic [31:0] w,
                                      input logic [1:0] q);
    logic [7:0] b;
    b = fbyte(w, q);
    q_ep = b[`UFC_EPNO_LSB +: 4]; // RULE2
  endfunction

  function automatic logic [1:0] q_dir(input logic [31:0] w,
                                       input logic [1:0] q);
    logic [7:0] b;
    b = fbyte(w, q);
    q_dir = b[`UFC_DIR_LSB +: 2]; // RULE2
  endfunction

  // byte n of the cfg word: en 5, size 4, count 3:2, kind 1:0
  function automatic logic q_en(input logic [31:0] w, input logic [1:0] q);
    logic [7:0] b;
    b = fbyte(w, q);
    q_en = b[`UFC_EN_BIT]; // RULE3 RULE4 RULE8 RULE9
  endfunction

  // endpoint map: endpoint k (1..8) sits in byte (k-1)%4 of its word
  function automatic logic [1:0] ep_queue(input logic [3:0] ep,
                                          input logic is_in,
                                          input logic [31:0] w0,
                                          input logic [31:0] w1);
    logic [3:0] idx;
    logic [31:0] w;
    logic [7:0] lane;
    idx = ep - 4'h1;
    w = idx[2] ? w1 : w0;
    lane = w[{idx[1:0], 3'h0} +: 8];
    ep_queue = is_in ? lane[`UFC_EPQ_IN_LSB +: 2]
                     : lane[`UFC_EPQ_OUT_LSB +: 2]; // RULE10
  endfunction

  // ===========================================================
  // packet lookup
  logic hit_next;
  logic [1:0] q_next;
  logic [7:0] cfg_b;
  logic [1:0] dir_q;
  logic [1:0] route_next;
  always_comb begin
    hit_next = 1'b0;
    q_next = 2'h0;
    route_next = 2'h3;
    if (pkt_ep >= 4'h1 && pkt_ep <= 4'h8) begin
      route_next = ep_queue(pkt_ep, pkt_is_in, epmap0_w, epmap1_w);
    end
    for (int i = NUM_FIFOS - 1; i >= 0; i--) begin
      dir_q = q_dir(fmap_w, 2'(i));
      // a disabled fifo never matches, whatever its mapping
      if (pkt_req && q_en(fcfg_w, 2'(i)) && q_ep(fmap_w, 2'(i)) == pkt_ep &&
          (dir_q == UFC_DIR_BIDIR ||
           dir_q == (pkt_is_in ? UFC_DIR_IN : UFC_DIR_OUT))) begin // RULE11
        hit_next = 1'b1;
        q_next = 2'(i);
      end
    end
    cfg_b = fbyte(fcfg_w, q_next);
  end

  logic hit_reg;
  logic [1:0] q_reg, cnt_reg, kind_reg, route_reg;
  logic [10:0] max_reg;
  logic [3:0] en_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [10:0] max_next;
  logic [1:0] cnt_next;
  logic [1:0] kind_next;
  logic [3:0] en_next;
  always_comb begin
    max_next = 11'h000;
    cnt_next = 2'h0;
    kind_next = 2'h0;
    // fields of a missed lookup read zero so a stale fifo is never implied
    if (hit_next) begin
      max_next = cfg_b[`UFC_SIZE_BIT] ? 11'(`UFC_LARGE_MAX)
                                      : 11'(`UFC_SMALL_MAX); // RULE5
      cnt_next = cfg_b[`UFC_CNT_LSB +: 2]; // RULE6
      kind_next = cfg_b[`UFC_KIND_LSB +: 2]; // RULE7
    end
    en_next = {q_en(fcfg_w, 2'h3), q_en(fcfg_w, 2'h2),
               q_en(fcfg_w, 2'h1), q_en(fcfg_w, 2'h0)}; // RULE3
    rdata_next = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `UFC_OFS_FMAP: rdata_next = fmap_w;
        `UFC_OFS_FCFG: rdata_next = fcfg_w;
        `UFC_OFS_EPMAP0: rdata_next = epmap0_w;
        `UFC_OFS_EPMAP1: rdata_next = epmap1_w;
        `UFC_OFS_STATUS: rdata_next = {28'h0000000, en_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_reg <= 1'b0;
      q_reg <= 2'h0;
      cnt_reg <= 2'h0;
      kind_reg <= 2'h0;
      max_reg <= 11'h000;
      route_reg <= 2'h3;
      en_reg <= 4'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      hit_reg <= hit_next; // RULE11
      q_reg <= q_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      max_reg <= max_next;
      route_reg <= route_next;
      en_reg <= en_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pkt_hit = hit_reg;
  assign pkt_queue = q_reg;
  assign pkt_buffer_count = cnt_reg;
  assign pkt_transfer_kind = kind_reg;
  assign pkt_max_size = max_reg;
  assign ep_route_queue = route_reg;
  assign queue_enable = en_reg;
  assign reg_rdata = rdata_reg;

  // ===========================================================
  // checks
  chk_disabled_no_hit: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_hit |-> queue_enable[pkt_queue]) // RULE11
    else $error("hit on a disabled fifo");
  chk_fmap_reset_val: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> fmap_w == `UFC_FMAP_RST) // RULE1
    else $error("map word reset wrong");
  chk_fmap_field_pos: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `UFC_OFS_FMAP) |=> fmap_w[29:28] ==
      $past(reg_wdata[29:28]) && fmap_w[31:30] == 2'h0) // RULE2
    else $error("map field not stored");
  chk_en3_bit_pos: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `UFC_OFS_FCFG) |=> ##1
      queue_enable[3] == $past(reg_wdata[29], 2)) // RULE3 RULE8
    else $error("fifo 3 enable bit wrong");
  chk_en2_bit_pos: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `UFC_OFS_FCFG) |=> fcfg_w[21:18] ==
      $past(reg_wdata[21:18])) // RULE4
    else $error("fifo 2 fields wrong");
  chk_max_size_sel: assert property (@(posedge clk) disable iff (sys_rst)
    pkt_hit |-> pkt_max_size == `UFC_SMALL_MAX ||
      pkt_max_size == `UFC_LARGE_MAX) // RULE5
    else $error("max size code wrong");
  chk_count_follows: assert property (@(posedge clk) disable iff (sys_rst)
    hit_next |=> pkt_buffer_count == $past(cfg_b[3:2])) // RULE6
    else $error("buffer count not forwarded");
  chk_kind_follows: assert property (@(posedge clk) disable iff (sys_rst)
    hit_next |=> pkt_transfer_kind == $past(cfg_b[1:0])) // RULE7
    else $error("transfer kind not forwarded");
  chk_fifo1_fields: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `UFC_OFS_FCFG) |=> fcfg_w[13:8] ==
      $past(reg_wdata[13:8]) && fcfg_w[5:0] == $past(reg_wdata[5:0])) // RULE9
    else $error("fifo 1 or 0 fields wrong");
  chk_epmap_reset: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> epmap0_w == `UFC_EPMAP_RST) // RULE10
    else $error("endpoint map reset wrong");
  chk_read_latency: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `UFC_OFS_FMAP && !reg_wr) |=>
      reg_rdata == $past(fmap_w))
    else $error("read data late or wrong");
  cov_hit: cover property (@(posedge clk) pkt_hit);
  cov_large: cover property (@(posedge clk)
    pkt_hit && pkt_max_size == `UFC_LARGE_MAX);
  cov_bidir_hit: cover property (@(posedge clk)
    hit_next && q_dir(fmap_w, q_next) == UFC_DIR_BIDIR);
endmodule
`default_nettype wire

// [bench/tb_ufc_fifo_map.sv]
// self-checking bench of the fifo mapping registers and lookup
`timescale 1ns/1ps
`default_nettype none
`include "ufc_params.svh"
module tb_ufc_fifo_map;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pkt_ep = 4'h0;
  logic pkt_is_in = 1'b0;
  logic pkt_req = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic pkt_hit;
  wire logic [1:0] pkt_queue;
  wire logic [10:0] pkt_max_size;
  wire logic [1:0] pkt_buffer_count;
  wire logic [1:0] pkt_transfer_kind;
  wire logic [1:0] ep_route_queue;
  wire logic [3:0] queue_enable;
  logic [31:0] m_fmap, m_fcfg, m_ep0, m_ep1;
  logic [31:0] rng = 32'h0000D9F6;
  logic [31:0] r;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  // unmapped 0x1B0 sits before status so writes can skip the status word
  logic [8:0] addrs [6] = '{`UFC_OFS_EPMAP0, `UFC_OFS_EPMAP1, `UFC_OFS_FMAP,
                            `UFC_OFS_FCFG, 9'h1B0, `UFC_OFS_STATUS};
  ufc_fifo_map dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pkt_ep(pkt_ep), .pkt_is_in(pkt_is_in),
    .pkt_req(pkt_req), .pkt_hit(pkt_hit), .pkt_queue(pkt_queue),
    .pkt_max_size(pkt_max_size), .pkt_buffer_count(pkt_buffer_count),
    .pkt_transfer_kind(pkt_transfer_kind),
    .ep_route_queue(ep_route_queue), .queue_enable(queue_enable));
  always #50 clk = ~clk;
  // ==========================================================
  // reference model
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic m_reset();
    m_fmap = 32'h0F0F0F0F;
    m_fcfg = 32'h00000000;
    m_ep0 = 32'h33333333;
    m_ep1 = 32'h33333333;
  endtask
  function automatic logic [31:0] m_read(input logic [8:0] a);
    case (a)
      `UFC_OFS_EPMAP0: return m_ep0;
      `UFC_OFS_EPMAP1: return m_ep1;
      `UFC_OFS_FMAP: return m_fmap;
      `UFC_OFS_FCFG: return m_fcfg;
      `UFC_OFS_STATUS: return {28'h0000000, m_fcfg[29], m_fcfg[21],
                               m_fcfg[13], m_fcfg[5]};
      default: return 32'h00000000;
    endcase
  endfunction
  // ==========================================================
  // checks and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    pkt_req <= 1'b0;
    @(posedge clk);
    reg_wr <= 1'b0;
    // reserved bits are dropped, reserved codes kept as written
    case (a)
      `UFC_OFS_EPMAP0: m_ep0 = d & 32'h33333333;
      `UFC_OFS_EPMAP1: m_ep1 = d & 32'h33333333;
      `UFC_OFS_FMAP: m_fmap = d & 32'h3F3F3F3F;
      `UFC_OFS_FCFG: m_fcfg = d & 32'h3F3F3F3F;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, m_read(a), "read");
  endtask
  task automatic look(input logic [3:0] ep, input logic is_in);
    logic hit;
    logic [1:0] q;
    logic [7:0] m;
    logic [7:0] c;
    logic [1:0] route;
    logic [31:0] w;
    hit = 1'b0;
    q = 2'h0;
    // walk downward so the lowest matching fifo is the one kept
    for (int i = 3; i >= 0; i--) begin
      m = m_fmap[8*i +: 8];
      c = m_fcfg[8*i +: 8];
      if (c[5] && m[3:0] == ep && (m[5:4] == 2'h2 ||
          m[5:4] == {1'b0, is_in})) begin
        hit = 1'b1;
        q = 2'(i);
      end
    end
    c = hit ? m_fcfg[8*q +: 8] : 8'h00;
    route = 2'h3;
    w = (ep <= 4'h4) ? m_ep0 : m_ep1;
    if (ep >= 4'h1 && ep <= 4'h8) begin
      route = w[8*((int'(ep) - 1) % 4) + (is_in ? 0 : 4) +: 2];
    end
    @(posedge clk);
    pkt_ep <= ep;
    pkt_is_in <= is_in;
    pkt_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'(pkt_hit), 32'(hit), "hit");
    chk(32'(pkt_queue), 32'(q), "queue");
    chk(32'(pkt_max_size), c[5] ? (c[4] ? 32'h400 : 32'h200) : 0, "size");
    chk(32'(pkt_buffer_count), 32'(c[3:2]), "count");
    chk(32'(pkt_transfer_kind), 32'(c[1:0]), "kind");
    chk(32'(ep_route_queue), 32'(route), "route");
    chk(32'(queue_enable), m_read(`UFC_OFS_STATUS), "enables");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    m_reset();
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(addrs[i]);
    look(4'hF, 1'b0);
    // fifo 2 bidir and fifo 3 in share ep 3; fifo 2 disabled on 2nd pass
    wr(`UFC_OFS_FMAP, 32'h13231201);
    wr(`UFC_OFS_EPMAP0, rnd());
    wr(`UFC_OFS_EPMAP1, rnd());
    for (int p = 0; p < 2; p++) begin
      wr(`UFC_OFS_FCFG, p == 0 ? 32'h392B3621 : 32'h390B3621);
      for (int e = 0; e < 10; e++) begin
        look(4'(e), 1'b0);
        look(4'(e), 1'b1);
      end
    end
    for (int n = 0; n < 300; n++) begin
      r = rnd();
      case (r[1:0])
        2'h0: wr(addrs[int'(r[4:2]) % 5], rnd());
        2'h1: rd(addrs[int'(r[4:2]) % 6]);
        default: look(r[11:8], r[12]);
      endcase
    end
    // second reset in mid-run must bring every word back to its default
    @(posedge clk);
    sys_rst <= 1'b1;
    m_reset();
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(addrs[i]);
    look(4'h3, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
